// *** inc/obt_cfg.svh ***
// Offsets, field positions, reset values and counts of the trace block.
// Assumes haddr[7:0] selects one aligned 32-bit register.
`ifndef OBT_CFG_SVH
`define OBT_CFG_SVH
`define OBT_A_CTRL 8'h00
`define OBT_A_QUAL 8'h04
`define OBT_A_SWBP 8'h08
`define OBT_A_C0AD 8'h0C
`define OBT_A_C0DT 8'h10
`define OBT_A_C1AD 8'h14
`define OBT_A_C1DT 8'h18
`define OBT_A_STAT 8'h1C
`define OBT_A_RIDX 8'h20
`define OBT_A_REC0 8'h24
`define OBT_A_REC1 8'h28
`define OBT_F_EN 0
`define OBT_F_BUS 1
`define OBT_F_FULL 2
`define OBT_F_SDMA 3
`define OBT_F_SXFR 4
`define OBT_F_SFET 5
`define OBT_F_SDAT 6
`define OBT_F_QEN 7
`define OBT_F_SWEN 8
`define OBT_F_WORD 16
`define OBT_F_WR 17
`define OBT_F_UDAT 18
`define OBT_F_UDIR 19
`define OBT_F_CEN 20
`define OBT_CTRL_RST 9'h000
`define OBT_HOLD_CYC 2'h2
`define OBT_RD_WAIT 2'h2
`define OBT_AW 8
`endif

// *** inc/obt_pkg.sv ***
// Types shared by the trace block files.
// Assumes nothing beyond a SystemVerilog compiler.
package obt_pkg;
  typedef enum logic [2:0] {
    OBT_AR_ROM = 3'h0, OBT_AR_RAM = 3'h1, OBT_AR_IO_BYTE = 3'h2,
    OBT_AR_IO_HALF = 3'h3, OBT_AR_EXT_BYTE = 3'h4,
    OBT_AR_EXT_HALF = 3'h5, OBT_AR_XFER = 3'h6
  } obt_area_t;
  typedef enum logic [2:0] {
    OBT_ST_FETCH = 3'h0, OBT_ST_DATA = 3'h1, OBT_ST_DMA = 3'h2,
    OBT_ST_XFER = 3'h3, OBT_ST_REFRESH = 3'h4
  } obt_status_t;
  typedef enum logic [1:0] {
    OBT_BK_RUN = 2'b01,
    OBT_BK_HOLD = 2'b10
  } obt_bkst_t;
  typedef struct packed {
    logic kind;
    logic irq;
    obt_status_t status;
    obt_area_t area;
    logic dir;
    logic [7:0] clocks;
    logic [15:0] data;
    logic [23:0] addr;
  } obt_rec_t;
endpackage

// *** inc/obt_mem_if.sv ***
// Port bundle between the trace controller and its record store.
// Assumes obt_pkg is compiled first.
`timescale 1ns/1ns
interface obt_mem_if;
  import obt_pkg::*;
  logic we;
  logic [7:0] waddr;
  logic [7:0] raddr;
  obt_rec_t wdata;
  obt_rec_t rdata;
  modport ctl(output we, waddr, wdata, raddr, input rdata);
  modport mem(input we, waddr, wdata, raddr, output rdata);
endinterface

// *** hw/obt_trace_mem.sv ***
// Record store of the trace unit, read data registered.
// Assumes one write and one read per clock.
`timescale 1ns/1ns
module obt_trace_mem
  import obt_pkg::*;
(
  input wire logic hclk,
  obt_mem_if.mem port
);
  obt_rec_t store [0:255];
  always_ff @(posedge hclk) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
    port.rdata <= store[port.raddr];
  end
endmodule // obt_trace_mem

// *** hw/obt_brk_chan.sv ***
// One hardware break-condition channel: address, data and direction match.
// Assumes the bus fields are valid while bus_last is high.
`timescale 1ns/1ns
module obt_brk_chan (
  input wire logic enable,
  input wire logic [23:0] cfg_addr,
  input wire logic [15:0] cfg_data,
  input wire logic cfg_word,
  input wire logic cfg_write,
  input wire logic use_data,
  input wire logic use_dir,
  input wire logic bus_last,
  input wire logic [23:0] bus_addr,
  input wire logic [15:0] bus_data,
  input wire logic bus_write,
  output logic hit
);
  logic addr_ok;
  logic data_ok;
  logic dir_ok;
  // Byte size compares only the low lane
  assign addr_ok = bus_addr == cfg_addr;
  assign data_ok = !use_data || (cfg_word ? bus_data == cfg_data
    : bus_data[7:0] == cfg_data[7:0]);
  assign dir_ok = !use_dir || bus_write == cfg_write;
  assign hit = enable && bus_last && addr_ok && data_ok && dir_ok;
endmodule // obt_brk_chan

// *** hw/obt_top.sv ***
// Break support and realtime trace unit with an AHB-Lite register slave.
// Assumes the monitored bus, branch and CPU strobes share hclk;
// only the interrupt request pins are asynchronous.
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
`include "obt_cfg.svh"
// Function
// - Odd breakpoint address is forced even
// - Single-step disables software breakpoints
// - Start at software breakpoint masks hardware matches
// - Step-over disables all break sources
// - Trace captures without halting the processor
// - Trace type selects branch or bus
// - Branch record holds branch-source address
// - Bus filters ignored in branch mode
// - Full capture records every bus cycle
// - Four cycle classes can be suppressed
// - Qualifier compares address bits 23 to 12
// - Record holds address, data, clock count
// - Record holds read or write code
// - Record holds access area class
// - Record holds bus status class
// - Record holds OR of sixteen request pins
// - Two channels match address, data, direction
module obt_top
  import obt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic bus_cyc,
  input wire logic bus_last,
  input wire logic [23:0] bus_addr,
  input wire logic [15:0] bus_data,
  input wire logic bus_write,
  input wire logic [2:0] bus_area,
  input wire logic [2:0] bus_status,
  input wire logic [15:0] interrupt_request_pins,
  input wire logic branch_valid,
  input wire logic [23:0] branch_src,
  input wire logic cpu_swbrk,
  input wire logic cpu_step,
  input wire logic cpu_stepover,
  input wire logic cpu_go,
  input wire logic [23:0] cpu_go_addr,
  output logic brk_req,
  output logic [1:0] brk_cause
);
  // ****************************************
  // Registers and bus slave
  // ****************************************
  logic [8:0] ctrl;
  logic [11:0] qual;
  logic [23:0] swbp;
  logic [23:0] c0_addr;
  logic [23:0] c1_addr;
  logic [20:0] c0_data;
  logic [20:0] c1_data;
  logic [7:0] ridx;
  logic wr_ph;
  logic rd_ph;
  logic [7:0] ph_addr;
  logic [1:0] rd_wait;
  logic take;
  logic take_rd;
  logic wr_do;
  logic [31:0] rd_mux;
  logic [31:0] stat;
  logic [7:0] wptr;
  logic wrapped;
  obt_bkst_t bk_st;
  obt_mem_if mif();

  assign take = hsel && htrans[1] && hready;
  assign take_rd = take && !hwrite;
  assign wr_do = wr_ph;
  assign hreadyout = !(rd_ph && rd_wait != 2'h0);
  assign hresp = 1'b0;
  assign stat = {12'h000, bk_st, brk_cause, 7'h00, wrapped, wptr};
  // Unmapped offsets read zero and ignore writes
  assign rd_mux =
    ph_addr == `OBT_A_CTRL ? {23'h0, ctrl} :
    ph_addr == `OBT_A_QUAL ? {20'h0, qual} :
    ph_addr == `OBT_A_SWBP ? {8'h00, swbp} :
    ph_addr == `OBT_A_C0AD ? {8'h00, c0_addr} :
    ph_addr == `OBT_A_C0DT ? {11'h0, c0_data} :
    ph_addr == `OBT_A_C1AD ? {8'h00, c1_addr} :
    ph_addr == `OBT_A_C1DT ? {11'h0, c1_data} :
    ph_addr == `OBT_A_STAT ? stat :
    ph_addr == `OBT_A_RIDX ? {24'h0, ridx} :
    ph_addr == `OBT_A_REC0 ? mif.rdata[31:0] :
    ph_addr == `OBT_A_REC1 ? {7'h00, mif.rdata[56:32]} :
    32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      rd_ph <= 1'b0;
      ph_addr <= 8'h00;
      rd_wait <= 2'h0;
    end else if (hreadyout) begin
      wr_ph <= take && hwrite;
      rd_ph <= take_rd;
      ph_addr <= take ? haddr[7:0] : ph_addr;
      rd_wait <= take_rd ? `OBT_RD_WAIT : 2'h0;
    end else begin
      rd_wait <= rd_wait - 2'h1;
    end
  end

  // Two wait states let a fresh read index reach the store output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_ph && rd_wait == 2'h1) begin
      hrdata <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `OBT_CTRL_RST;
      qual <= 12'h000;
      swbp <= 24'h00_0000;
      c0_addr <= 24'h00_0000;
      c1_addr <= 24'h00_0000;
      c0_data <= 21'h00_0000;
      c1_data <= 21'h00_0000;
      ridx <= 8'h01;
    end else if (wr_do) begin
      case (ph_addr)
        `OBT_A_CTRL: ctrl <= hwdata[8:0];
        `OBT_A_QUAL: qual <= hwdata[11:0];
        `OBT_A_SWBP: swbp <= {hwdata[23:1], 1'b0};
        `OBT_A_C0AD: c0_addr <= {hwdata[23:1], 1'b0};
        `OBT_A_C0DT: c0_data <= hwdata[20:0];
        `OBT_A_C1AD: c1_addr <= {hwdata[23:1], 1'b0};
        `OBT_A_C1DT: c1_data <= hwdata[20:0];
        `OBT_A_RIDX: ridx <= hwdata[7:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  // ****************************************
  // Trace capture
  // ****************************************
  logic [15:0] irq_s1;
  logic [15:0] irq_s2;
  logic [7:0] bc_cnt;
  logic trace_en;
  logic bus_mode;
  logic full;
  logic qual_en;
  logic sup_hit;
  logic qual_ok;
  logic bus_keep;
  logic rec_we;
  obt_rec_t bus_rec;
  obt_rec_t br_rec;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_s1 <= 16'h0000;
      irq_s2 <= 16'h0000;
    end else begin
      irq_s1 <= interrupt_request_pins;
      irq_s2 <= irq_s1;
    end
  end

  // Counts clocks of the current bus cycle; wraps past 255
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bc_cnt <= 8'h00;
    end else if (bus_last) begin
      bc_cnt <= 8'h00;
    end else if (bus_cyc) begin
      bc_cnt <= bc_cnt + 8'h01;
    end
  end

  assign trace_en = ctrl[`OBT_F_EN];
  assign bus_mode = ctrl[`OBT_F_BUS];
  assign full = ctrl[`OBT_F_FULL];
  assign qual_en = ctrl[`OBT_F_QEN];
  assign sup_hit =
    (bus_status == OBT_ST_DMA && ctrl[`OBT_F_SDMA]) ||
    (bus_status == OBT_ST_XFER && ctrl[`OBT_F_SXFR]) ||
    (bus_status == OBT_ST_FETCH && ctrl[`OBT_F_SFET]) ||
    (bus_status == OBT_ST_DATA && ctrl[`OBT_F_SDAT]);
  assign qual_ok = !qual_en || bus_addr[23:12] == qual;
  assign bus_keep = full || (!sup_hit && qual_ok);
  // Capture never touches brk_req, so the CPU keeps running
  assign rec_we = trace_en && (bus_mode ? bus_last && bus_keep
    : branch_valid);

  assign bus_rec.kind = 1'b1;
  assign bus_rec.irq = |irq_s2;
  assign bus_rec.status = obt_status_t'(bus_status);
  assign bus_rec.area = obt_area_t'(bus_area);
  assign bus_rec.dir = bus_write;
  assign bus_rec.clocks = bc_cnt + 8'h01;
  assign bus_rec.data = bus_data;
  assign bus_rec.addr = bus_addr;
  assign br_rec = '{kind: 1'b0, irq: 1'b0, status: OBT_ST_FETCH,
    area: OBT_AR_ROM, dir: 1'b0, clocks: 8'h00, data: 16'h0000,
    addr: branch_src};

  assign mif.we = rec_we;
  assign mif.waddr = wptr;
  assign mif.wdata = bus_mode ? bus_rec : br_rec;
  // Offset 1 is the newest record, older ones further back
  assign mif.raddr = wptr - ridx;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wptr <= 8'h00;
      wrapped <= 1'b0;
    end else if (rec_we) begin
      wptr <= wptr + 8'h01;
      wrapped <= wrapped || wptr == 8'hFF;
    end
  end

  obt_trace_mem u_mem (
    .hclk(hclk),
    .port(mif.mem)
  );

  // ****************************************
  // Break logic
  // ****************************************
  logic c0_hit;
  logic c1_hit;
  logic hw_hit;
  logic sw_hit;
  logic sw_en;
  logic go_sw;
  logic [1:0] hold_cnt;
  obt_bkst_t next_bk_st;

  assign sw_en = ctrl[`OBT_F_SWEN];

  obt_brk_chan u_ch0 (
    .enable(c0_data[`OBT_F_CEN]),
    .cfg_addr(c0_addr),
    .cfg_data(c0_data[15:0]),
    .cfg_word(c0_data[`OBT_F_WORD]),
    .cfg_write(c0_data[`OBT_F_WR]),
    .use_data(c0_data[`OBT_F_UDAT]),
    .use_dir(c0_data[`OBT_F_UDIR]),
    .bus_last(bus_last),
    .bus_addr(bus_addr),
    .bus_data(bus_data),
    .bus_write(bus_write),
    .hit(c0_hit)
  );

  obt_brk_chan u_ch1 (
    .enable(c1_data[`OBT_F_CEN]),
    .cfg_addr(c1_addr),
    .cfg_data(c1_data[15:0]),
    .cfg_word(c1_data[`OBT_F_WORD]),
    .cfg_write(c1_data[`OBT_F_WR]),
    .use_data(c1_data[`OBT_F_UDAT]),
    .use_dir(c1_data[`OBT_F_UDIR]),
    .bus_last(bus_last),
    .bus_addr(bus_addr),
    .bus_data(bus_data),
    .bus_write(bus_write),
    .hit(c1_hit)
  );

  assign go_sw = cpu_go && sw_en && cpu_go_addr == swbp;
  assign hw_hit = (c0_hit || c1_hit) && !cpu_stepover
    && bk_st != OBT_BK_HOLD;
  assign sw_hit = cpu_swbrk && sw_en && !cpu_step
    && !cpu_stepover;

  always_comb begin
    next_bk_st = bk_st;
    case (bk_st)
      OBT_BK_RUN: if (go_sw) next_bk_st = OBT_BK_HOLD;
      OBT_BK_HOLD: if (hold_cnt == 2'h1) next_bk_st = OBT_BK_RUN;
      default: next_bk_st = OBT_BK_RUN;
    endcase
  end

  // Short holdoff: only matches right after the start are masked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bk_st <= OBT_BK_RUN;
      hold_cnt <= 2'h0;
    end else begin
      bk_st <= next_bk_st;
      hold_cnt <= go_sw ? `OBT_HOLD_CYC
        : (hold_cnt != 2'h0 ? hold_cnt - 2'h1 : 2'h0);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brk_req <= 1'b0;
      brk_cause <= 2'h0;
    end else begin
      brk_req <= hw_hit || sw_hit;
      if (hw_hit || sw_hit) begin
        brk_cause <= {sw_hit, hw_hit};
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_go_sw;
    cpu_go && sw_en && cpu_go_addr == swbp;
  endsequence
  sequence s_quiet2;
    !cpu_swbrk [*2];
  endsequence
  // End of a traced bus cycle, kept as a wire to mix with booleans
  logic bus_end;
  assign bus_end = trace_en && bus_mode && bus_last;

  a_even_addr: assert property (!swbp[0] && !c0_addr[0]
    && !c1_addr[0]) else $error("odd break address");
  a_step_no_sw: assert property (cpu_swbrk && cpu_step && !c0_hit
    && !c1_hit |=> !brk_req) else $error("break in step");
  a_hold_masks: assert property (s_go_sw ##1 s_quiet2 |=> !brk_req)
    else $error("break after start");
  a_stepover_off: assert property (cpu_stepover |=> !brk_req)
    else $error("break in step-over");
  a_full_all: assert property (bus_end && full
    |=> wptr == 8'($past(wptr) + 8'h01))
    else $error("full capture lost");
  a_sup_skip: assert property (bus_end && !full && sup_hit
    |=> $stable(wptr) && $stable(wrapped))
    else $error("suppressed cycle stored");
  a_branch_free: assert property (trace_en && !bus_mode
    && branch_valid |=> wptr == 8'($past(wptr) + 8'h01))
    else $error("branch filtered");
  a_qual_low: assert property (bus_end && !full && !sup_hit
    && qual_en && bus_addr[23:12] != qual |=> $stable(wptr))
    else $error("qualifier miss stored");
  a_read_wait: assert property (take_rd && hreadyout
    |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
endmodule // obt_top

// *** testbench/obt_cpu_bus_model.sv ***
// Model of the monitored processor bus feeding the trace block.
// Assumes one bus cycle at a time, started by a one-clock start pulse.
`timescale 1ns/1ns
module obt_cpu_bus_model (
  input wire logic hclk,
  input wire logic start,
  input wire logic [7:0] nclk,
  input wire logic [23:0] a,
  input wire logic [15:0] d,
  input wire logic w,
  input wire logic [2:0] ar,
  input wire logic [2:0] st,
  output logic bus_cyc,
  output logic bus_last,
  output logic [23:0] bus_addr,
  output logic [15:0] bus_data,
  output logic bus_write,
  output logic [2:0] bus_area,
  output logic [2:0] bus_status,
  output logic busy
);
  logic [7:0] left = 8'h00;
  initial begin
    {bus_cyc, bus_last, bus_addr, bus_data} = '0;
    {bus_write, bus_area, bus_status} = '0;
  end
  assign busy = (left != 8'h00);
  // Address, data and direction are inverted when idle so no stale value passes for a live one
  always @(posedge hclk) begin
    if (left == 8'h00 && start) begin
      {bus_cyc, bus_addr, bus_data, bus_write} <= {1'b1, a, d, w};
      {bus_area, bus_status, left} <= {ar, st, nclk};
      bus_last <= (nclk == 8'h01);
    end else if (left > 8'h01) begin
      left <= left - 8'h01;
      bus_last <= (left == 8'h02);
    end else if (left == 8'h01) begin
      {left, bus_cyc, bus_last} <= '0;
      {bus_addr, bus_data, bus_write} <= ~{bus_addr, bus_data, bus_write};
    end
  end
endmodule // obt_cpu_bus_model

// *** testbench/onchip_break_and_bus_trace_tb.sv ***
// Self-checking bench: AHB-Lite register access, trace capture, breaks.
// Assumes the package, interface, design files and bus model come first.
`timescale 1ns/1ns
`include "obt_cfg.svh"
module onchip_break_and_bus_trace_tb
  import obt_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, brk_req;
  logic [1:0] brk_cause;
  logic [15:0] irq_pins = 16'h0;
  logic branch_valid = 1'b0;
  logic [23:0] branch_src = 24'h0, cpu_go_addr = 24'h0, b_a = 24'h0;
  logic cpu_swbrk = 1'b0, cpu_step = 1'b0, cpu_stepover = 1'b0;
  logic cpu_go = 1'b0, b_go = 1'b0, b_w = 1'b0;
  logic [15:0] b_d = 16'h0;
  logic [7:0] b_n = 8'h01;
  logic [2:0] b_ar = 3'h0, b_st = 3'h0;
  logic bc, bl, bw, b_busy;
  logic [23:0] ba;
  logic [15:0] bd;
  logic [2:0] bar, bst;
  int n_fail = 0, compares = 0, n_brk = 0;
  always #4 hclk = ~hclk;
  always @(posedge hclk) if (brk_req === 1'b1) n_brk <= n_brk + 1;
  obt_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .bus_cyc(bc), .bus_last(bl), .bus_addr(ba),
    .bus_data(bd), .bus_write(bw), .bus_area(bar), .bus_status(bst),
    .interrupt_request_pins(irq_pins), .branch_valid(branch_valid),
    .branch_src(branch_src), .cpu_swbrk(cpu_swbrk), .cpu_step(cpu_step),
    .cpu_stepover(cpu_stepover), .cpu_go(cpu_go),
    .cpu_go_addr(cpu_go_addr), .brk_req(brk_req), .brk_cause(brk_cause));
  obt_cpu_bus_model bm (.hclk(hclk), .start(b_go), .nclk(b_n), .a(b_a),
    .d(b_d), .w(b_w), .ar(b_ar), .st(b_st), .bus_cyc(bc), .bus_last(bl),
    .bus_addr(ba), .bus_data(bd), .bus_write(bw), .bus_area(bar),
    .bus_status(bst), .busy(b_busy));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    compares++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // Ready and read data are taken at the rising edge ending each phase
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(nm, {32'h0, e}, {32'h0, q & m});
  endtask
  task automatic rec(input logic [7:0] n, output obt_rec_t r);
    logic [31:0] lo, hi;
    wr(`OBT_A_RIDX, {24'h0, n});
    ahb(1'b0, `OBT_A_REC0, 32'h0, lo);
    ahb(1'b0, `OBT_A_REC1, 32'h0, hi);
    r = {hi[24:0], lo};
  endtask
  task automatic cyc(input logic [23:0] a, input logic [15:0] d,
    input logic w, input int ar, input int st, input logic [7:0] n,
    input logic g);
    @(posedge hclk);
    {b_a, b_d, b_w, b_n, b_go, cpu_go} <= {a, d, w, n, 1'b1, g};
    {b_ar, b_st} <= {3'(ar), 3'(st)};
    @(posedge hclk);
    {b_go, cpu_go} <= 2'b00;
    do @(negedge hclk); while (b_busy);
    repeat (4) @(posedge hclk);
  endtask
  task automatic sw_pulse();
    @(posedge hclk);
    cpu_swbrk <= 1'b1;
    @(posedge hclk);
    cpu_swbrk <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk("ctrl", `OBT_A_CTRL, 32'hFFFFFFFF, 32'h0);
    rd_chk("ridx", `OBT_A_RIDX, 32'hFFFFFFFF, 32'h1);
    rd_chk("wptr", `OBT_A_STAT, 32'hFF, 32'h0);
    rd_chk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
    chk("hresp", 64'h0, {63'h0, hresp});
    $display("test reset done");
  endtask
  task automatic t_full();
    obt_rec_t r;
    irq_pins <= 16'h0100;
    wr(`OBT_A_CTRL, 32'h7F);
    cyc(24'hABC123, 16'hBEEF, 1'b1, 4, 3, 8'h03, 1'b0);
    rd_chk("wptr", `OBT_A_STAT, 32'hFF, 32'h1);
    rec(8'h01, r);
    chk("record", 64'h01_B9_03BEEF_ABC123, {7'h0, r});
    $display("test full done");
  endtask
  task automatic t_suppress();
    obt_rec_t r;
    irq_pins <= 16'h0;
    wr(`OBT_A_CTRL, 32'h7B);
    for (int s = 0; s < 4; s++) cyc(24'h1000, 16'h1, 1'b0, 1, s, 8'h01, 1'b0);
    rd_chk("wptr", `OBT_A_STAT, 32'hFF, 32'h1);
    cyc(24'h000456, 16'h0A0B, 1'b0, 0, 4, 8'h01, 1'b0);
    rec(8'h01, r);
    chk("record", 64'h01_40_010A0B_000456, {7'h0, r});
    $display("test suppress done");
  endtask
  task automatic t_qual();
    obt_rec_t r;
    wr(`OBT_A_QUAL, 32'hABC);
    wr(`OBT_A_CTRL, 32'h83);
    cyc(24'hABD000, 16'h2, 1'b0, 1, 1, 8'h01, 1'b0);
    rd_chk("wptr", `OBT_A_STAT, 32'hFF, 32'h2);
    cyc(24'hABCFFF, 16'h3, 1'b0, 1, 1, 8'h01, 1'b0);
    rec(8'h01, r);
    chk("addr", 64'hABCFFF, {40'h0, r.addr});
    $display("test qualifier done");
  endtask
  // Qualifier and suppress bits stay set: branch mode must ignore them
  task automatic t_branch();
    obt_rec_t r;
    int n_hit;
    int first;
    n_hit = 0;
    first = 0;
    wr(`OBT_A_QUAL, 32'h0);
    wr(`OBT_A_CTRL, 32'hF9);
    @(posedge hclk);
    {branch_valid, branch_src} <= {1'b1, 24'h100100};
    @(posedge hclk);
    branch_src <= 24'h100200;
    @(posedge hclk);
    {branch_valid, branch_src} <= {1'b0, 24'hEFFDFF};
    cyc(24'hABC000, 16'h4, 1'b0, 1, 1, 8'h01, 1'b0);
    rd_chk("wptr", `OBT_A_STAT, 32'hFF, 32'h5);
    rec(8'h01, r);
    chk("newest", 64'h100200, {39'h0, r.kind, r.addr});
    rec(8'h02, r);
    chk("older", 64'h100100, {39'h0, r.kind, r.addr});
    // Host searches: filter counts every match, find keeps the first
    for (int k = 1; k <= 5; k++) begin
      rec(8'(k), r);
      if (!r.kind && r.addr[23:20] == 4'h1) n_hit++;
      if (first == 0 && r.addr == 24'h100100) first = k;
    end
    chk("filter", 64'h2, 64'(n_hit));
    chk("find", 64'h2, 64'(first));
    $display("test branch done");
  endtask
  task automatic t_break();
    int n0;
    wr(`OBT_A_CTRL, 32'h100);
    wr(`OBT_A_SWBP, 32'h2001);
    rd_chk("swbp", `OBT_A_SWBP, 32'hFFFFFF, 32'h2000);
    // Channel watches a data word, never the patched instruction
    wr(`OBT_A_C0AD, 32'h4000);
    wr(`OBT_A_C0DT, 32'h100000);
    n0 = n_brk;
    sw_pulse();
    chk("sw break", n0 + 1, n_brk);
    chk("cause", 64'h2, {62'h0, brk_cause});
    cpu_step <= 1'b1;
    sw_pulse();
    cpu_step <= 1'b0;
    chk("step break", n0 + 1, n_brk);
    cyc(24'h4000, 16'h5, 1'b0, 1, 1, 8'h01, 1'b0);
    chk("hw break", n0 + 2, n_brk);
    chk("cause", 64'h1, {62'h0, brk_cause});
    cpu_stepover <= 1'b1;
    sw_pulse();
    cyc(24'h4000, 16'h5, 1'b0, 1, 1, 8'h01, 1'b0);
    cpu_stepover <= 1'b0;
    chk("stepover", n0 + 2, n_brk);
    cpu_go_addr <= 24'h2000;
    cyc(24'h4000, 16'h5, 1'b0, 1, 1, 8'h01, 1'b1);
    chk("go at swbp", n0 + 2, n_brk);
    cpu_go_addr <= 24'h3000;
    cyc(24'h4000, 16'h5, 1'b0, 1, 1, 8'h01, 1'b1);
    chk("go elsewhere", n0 + 3, n_brk);
    $display("test break done");
  endtask
  // ****************************************
  // Sequence and verdict
  // ****************************************
  task automatic give_verdict();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_full();
    t_suppress();
    t_qual();
    t_branch();
    t_break();
    give_verdict();
  end
  // Whole run needs under a thousand cycles; this is ten times that
  initial begin
    #80000;
    n_fail++;
    give_verdict();
  end
endmodule // onchip_break_and_bus_trace_tb
